// ==== design/ccu_top.sv ====
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "ccu_params.svh"
// How it works
// - Capture/compare use the two counting timers
// - Setting 00: every unit on timer a
// - Setting 01: only unit one on timer a
// - Setting 10: units one and two on a
// - Setting 11: every unit on timer b
// - Selection bits sit at bits 6, 3
// - Capture copies assigned timer into result
// - Four capture events, chosen by mode
// - Modes 0100 to 0111 decode capture events
// - Capture sets flag, only software clears
// - New capture overwrites unread result
// - Edges seen even while pin drives
// - Prescaler cleared unless in capture mode
// - Prescale change keeps the counter
// - Compare result against timer continuously
// - Match acts on pin, sets flag together
// - Compare modes 0010, 1000 to 1011
// - Mode 0000 disables and resets unit
// - Clearing control forces output latch low
// - Interrupt-only mode leaves pin untouched
// - Special event of units one, two resets timer
// - Unit two special event starts conversion
// - That timer reset sets no timer flag
module ccu_top
   import ccu_pkg::*;
#(
   parameter int NUM_UNITS = `CCU_NUM_UNITS
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`CCU_AW-1:0]   paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Timers and converter
   input  wire logic [`CCU_TW-1:0]   timer_a_count,
   input  wire logic [`CCU_TW-1:0]   timer_b_count,
   input  wire logic                 adc_enable,
   output logic                      timer_a_reset,
   output logic                      timer_b_reset,
   output logic                      adc_start,
   // Unit pins
   input  wire logic [NUM_UNITS-1:0] unit_pin_in,
   output logic      [NUM_UNITS-1:0] unit_pin_out,
   output logic      [NUM_UNITS-1:0] unit_pin_own,
   // Flags
   output logic      [NUM_UNITS-1:0] unit_irq_flag,
   output logic      [NUM_UNITS-1:0] unit_irq_req
);
   // ------------------------------------------------
   // State
   // ------------------------------------------------
   typedef struct packed {
      ccu_bus_ph_t                ph;     // Bus phase
      logic [31:0]                prdata; // Read data
      logic                       err;    // Error answer
      logic [NUM_UNITS-1:0][3:0]  mode;   // Unit modes
      logic [1:0]                 tsel;   // Timer assignment
      logic [NUM_UNITS-1:0]       flag;   // Sticky flags
      logic [NUM_UNITS-1:0]       ien;    // Flag enables
      logic [NUM_UNITS-1:0]       req;    // Enabled flags
      logic                       rst_a;  // Timer a reset
      logic                       rst_b;  // Timer b reset
      logic                       adc;    // Conversion start
   } ccu_top_st_t;

   ccu_top_st_t q;                          // Registered state
   ccu_top_st_t d;                          // Next state
   logic [NUM_UNITS-1:0][`CCU_TW-1:0] res_w; // Unit results
   logic [NUM_UNITS-1:0] cap_w;             // Capture events
   logic [NUM_UNITS-1:0] cmp_w;             // Match events
   logic [NUM_UNITS-1:0] spec_w;            // Special events
   logic [NUM_UNITS-1:0] clr;               // Flag clear mask
   logic                 wr;                // Write commit
   int unsigned          uidx;              // Addressed unit

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   // Whether a unit takes timer a under a setting
   function automatic logic uses_a(input int unsigned idx,
                                   input logic [1:0] ts);
      case (ts)
         `CCU_TS_ALL_A: uses_a = 1'b1;
         `CCU_TS_ONE_A: uses_a = (idx == 0);
         `CCU_TS_TWO_A: uses_a = (idx < 2);
         `CCU_TS_ALL_B: uses_a = 1'b0;
         default:       uses_a = 1'b1;
      endcase
   endfunction : uses_a

   // Whether an address lands in a unit window
   function automatic logic in_units(
      input logic [`CCU_AW-1:0] a);
      in_units = (a < `CCU_AW'(NUM_UNITS * `CCU_STRIDE));
   endfunction : in_units

   // Whether an address is a mapped register
   function automatic logic mapped(input logic [`CCU_AW-1:0] a);
      mapped = (a[1:0] == 2'h0) &&
               (in_units(a) || a == `CCU_OFS_TSEL ||
                a == `CCU_OFS_FLAG || a == `CCU_OFS_IEN);
   endfunction : mapped

   // ------------------------------------------------
   // Units
   // ------------------------------------------------
   // Only capture/compare timers are routed here; the
   // modulation timers belong to a separate block.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
         ccu_unit_if ui ();
         // Count of the assigned timer
         assign ui.tcount = uses_a(gi, q.tsel) ? timer_a_count
                                              : timer_b_count;
         assign ui.mode   = q.mode[gi];
         assign ui.res_wr = wr && in_units(paddr) &&
                            (uidx == gi) &&
                            (paddr[2:0] == `CCU_OFS_RES);
         assign ui.wdata  = pwdata[`CCU_TW-1:0];
         assign res_w[gi] = ui.result;
         assign cap_w[gi] = ui.cap_hit;
         assign cmp_w[gi] = ui.cmp_hit;
         assign spec_w[gi] = ui.spec_hit;
         assign unit_pin_out[gi] = ui.pin_out;
         assign unit_pin_own[gi] = ui.pin_own;

         ccu_unit #(
            .UNIT_IDX (gi)
         ) u_unit (
            .pclk    (pclk),
            .presetn (presetn),
            .pin_in  (unit_pin_in[gi]),
            .u       (ui.unit)
         );
      end
   endgenerate

   assign uidx = 32'(paddr >> 3);
   // A write lands on the edge that sees pready high
   assign wr = psel && penable && pwrite &&
               (q.ph == CCU_BUS_ANSWER) && !q.err;

   // ------------------------------------------------
   // Next state
   // ------------------------------------------------
   always_comb begin
      d = q;
      clr = '0;
      // Bus: one wait cycle, then answer for one cycle
      case (q.ph)
         CCU_BUS_IDLE: begin
            if (psel && penable) begin
               d.ph = CCU_BUS_ANSWER;
               d.err = !mapped(paddr);
               d.prdata = 32'h0000_0000;
               if (!pwrite && in_units(paddr)) begin
                  for (int i = 0; i < NUM_UNITS; i++) begin
                     if (uidx == i) begin
                        if (paddr[2:0] == `CCU_OFS_CTRL) begin
                           d.prdata[3:0] = q.mode[i];
                        end else begin
                           d.prdata[`CCU_TW-1:0] = res_w[i];
                        end
                     end
                  end
               end else if (!pwrite) begin
                  case (paddr)
                     `CCU_OFS_TSEL: begin
                        // Split selection field
                        d.prdata[`CCU_TSEL_HI_BIT] = q.tsel[1];
                        d.prdata[`CCU_TSEL_LO_BIT] = q.tsel[0];
                     end
                     `CCU_OFS_FLAG:
                        d.prdata[NUM_UNITS-1:0] = q.flag;
                     `CCU_OFS_IEN:
                        d.prdata[NUM_UNITS-1:0] = q.ien;
                     default: d.prdata = 32'h0000_0000;
                  endcase
               end
            end
         end
         CCU_BUS_ANSWER: begin
            // Unmapped or unaligned writes are dropped
            d.ph = CCU_BUS_IDLE;
            d.err = 1'b0;
         end
         default: d.ph = CCU_BUS_IDLE;
      endcase
      // Register writes
      if (wr) begin
         if (in_units(paddr)) begin
            for (int i = 0; i < NUM_UNITS; i++) begin
               if (uidx == i && paddr[2:0] == `CCU_OFS_CTRL) begin
                  d.mode[i] = pwdata[3:0];
               end
            end
         end else begin
            case (paddr)
               `CCU_OFS_TSEL: begin
                  d.tsel = {pwdata[`CCU_TSEL_HI_BIT],
                            pwdata[`CCU_TSEL_LO_BIT]};
               end
               `CCU_OFS_FLAG:
                  clr = pwdata[NUM_UNITS-1:0];
               `CCU_OFS_IEN:
                  d.ien = pwdata[NUM_UNITS-1:0];
               default: d.ien = q.ien;
            endcase
         end
      end
      // Flags: write one to clear, a new event wins
      d.flag = (q.flag & ~clr) | cap_w | cmp_w;
      d.req = d.flag & d.ien;
      // Timer resets from special events; these are
      // separate strobes and never reach timer flags.
      d.rst_a = 1'b0;
      d.rst_b = 1'b0;
      for (int i = 0; i < NUM_UNITS; i++) begin
         if (spec_w[i]) begin
            if (uses_a(i, q.tsel)) begin
               d.rst_a = 1'b1;
            end else begin
               d.rst_b = 1'b1;
            end
         end
      end
      // Unit two also starts a conversion when enabled
      d.adc = (NUM_UNITS > 1) && spec_w[NUM_UNITS > 1 ? 1 : 0]
              && adc_enable;
   end

   // ------------------------------------------------
   // State register
   // ------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{ph: CCU_BUS_IDLE, prdata: 32'h0000_0000,
                err: 1'b0, mode: '0, tsel: `CCU_RST_TSEL,
                flag: '0, ien: '0, req: '0, rst_a: 1'b0,
                rst_b: 1'b0, adc: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------
   // Outputs
   // ------------------------------------------------
   assign prdata        = q.prdata;
   assign pready        = (q.ph == CCU_BUS_ANSWER);
   assign pslverr       = q.err;
   assign timer_a_reset = q.rst_a;
   assign timer_b_reset = q.rst_b;
   assign adc_start     = q.adc;
   assign unit_irq_flag = q.flag;
   assign unit_irq_req  = q.req;
endmodule : ccu_top

// ==== design/ccu_unit.sv ====
`timescale 1ns/100ps
`include "ccu_params.svh"
module ccu_unit
   import ccu_pkg::*;
#(
   parameter int UNIT_IDX = 0
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin level, asynchronous
   input wire logic pin_in,
   // Control side
   ccu_unit_if.unit u
);
   ccu_unit_st_t q;   // Registered state
   ccu_unit_st_t d;   // Next state
   logic is_cap;      // Any capture mode
   logic is_cmp;      // Any compare mode
   logic rise;        // Synchronised rising edge
   logic fall;        // Synchronised falling edge
   logic hit;         // First cycle of equality
   logic cap;         // Capture event

   // ------------------------------------------------
   // Next state
   // ------------------------------------------------
   always_comb begin
      d = q;
      // Two stages, edge taken from second only
      d.sync1 = pin_in;
      d.sync2 = q.sync1;
      d.level = q.sync2;
      // Pin seen even when driven as output
      rise = q.sync2 & ~q.level;
      fall = ~q.sync2 & q.level;
      is_cap = (u.mode[3:2] == 2'b01);
      is_cmp = (u.mode == `CCU_M_TOGGLE) || (u.mode[3:2] == 2'b10);
      // Continuous equality, acted on once per match
      d.match_q = is_cmp && (u.tcount == q.result);
      hit = d.match_q & ~q.match_q;
      d.mode_seen = u.mode;
      d.own = (u.mode == `CCU_M_TOGGLE) || (u.mode == `CCU_M_SET_HI)
              || (u.mode == `CCU_M_SET_LO);
      // Counter kept across capture to capture switches
      if (!is_cap) begin
         d.presc = 4'h0;
      end
      // Initial level set on entry to a set-high or set-low compare mode
      if (u.mode != q.mode_seen) begin
         if (u.mode == `CCU_M_SET_HI) begin
            d.out = 1'b0;
         end else if (u.mode == `CCU_M_SET_LO) begin
            d.out = 1'b1;
         end
      end
      // Event select
      cap = 1'b0;
      case (u.mode)
         `CCU_M_CAP_FALL: cap = fall;
         `CCU_M_CAP_RISE: cap = rise;
         `CCU_M_CAP_4, `CCU_M_CAP_16: begin
            // Count rising edges, capture on wrap
            if (rise) begin
               d.presc = q.presc + 4'h1;
               cap = (u.mode == `CCU_M_CAP_4)
                  ? ((q.presc & `CCU_PRE4_MASK) == `CCU_PRE4_MASK)
                  : (q.presc == `CCU_PRE16_MASK);
            end
         end
         default: cap = 1'b0;
      endcase
      // Software write, a capture in the same cycle wins
      if (u.res_wr) begin
         d.result = u.wdata;
      end
      if (cap) begin
         d.result = u.tcount;
      end
      // Pin action on match
      u.spec_hit = 1'b0;
      if (hit) begin
         case (u.mode)
            `CCU_M_TOGGLE: d.out = ~q.out;
            `CCU_M_SET_HI: d.out = 1'b1;
            `CCU_M_SET_LO: d.out = 1'b0;
            `CCU_M_SPECIAL: u.spec_hit = (UNIT_IDX < 2);
            default: d.out = q.out;
         endcase
      end
      // Off clears internal state and output latch
      if (u.mode == `CCU_M_OFF) begin
         d.out = 1'b0;
         d.match_q = 1'b0;
      end
      u.cap_hit = cap;
      u.cmp_hit = hit;
   end

   // ------------------------------------------------
   // State register
   // ------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{sync1: 1'b0, sync2: 1'b0, level: 1'b0,
                presc: 4'h0, out: 1'b0, own: 1'b0,
                mode_seen: `CCU_RST_MODE, match_q: 1'b0,
                result: `CCU_RST_RES};
      end else begin
         q <= d;
      end
   end

   assign u.result  = q.result;
   assign u.pin_out = q.out;
   assign u.pin_own = q.own;
endmodule : ccu_unit

// ==== inc/ccu_params.svh ====
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH
// ------------------------------------------------
// Sizes
// ------------------------------------------------
`define CCU_NUM_UNITS 5
`define CCU_TW 16
`define CCU_AW 12
// ------------------------------------------------
// Register byte offsets
// ------------------------------------------------
`define CCU_STRIDE 12'h008
`define CCU_OFS_CTRL 3'h0
`define CCU_OFS_RES 3'h4
`define CCU_OFS_TSEL 12'h040
`define CCU_OFS_FLAG 12'h044
`define CCU_OFS_IEN 12'h048
// ------------------------------------------------
// Field positions
// ------------------------------------------------
`define CCU_TSEL_HI_BIT 6
`define CCU_TSEL_LO_BIT 3
// ------------------------------------------------
// Mode codes
// ------------------------------------------------
`define CCU_M_OFF 4'h0
`define CCU_M_TOGGLE 4'h2
`define CCU_M_CAP_FALL 4'h4
`define CCU_M_CAP_RISE 4'h5
`define CCU_M_CAP_4 4'h6
`define CCU_M_CAP_16 4'h7
`define CCU_M_SET_HI 4'h8
`define CCU_M_SET_LO 4'h9
`define CCU_M_SOFT 4'hA
`define CCU_M_SPECIAL 4'hB
`define CCU_PRE4_MASK 4'h3
`define CCU_PRE16_MASK 4'hF
// ------------------------------------------------
// Timer assignment settings
// ------------------------------------------------
`define CCU_TS_ALL_A 2'h0
`define CCU_TS_ONE_A 2'h1
`define CCU_TS_TWO_A 2'h2
`define CCU_TS_ALL_B 2'h3
// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define CCU_RST_MODE 4'h0
`define CCU_RST_RES 16'h0000
`define CCU_RST_TSEL 2'h0
`endif

// ==== inc/ccu_pkg.sv ====
`include "ccu_params.svh"
package ccu_pkg;
   typedef logic [3:0]         ccu_mode_t;
   typedef logic [`CCU_TW-1:0] ccu_word_t;
   // Bus answer phase
   typedef enum logic {CCU_BUS_IDLE, CCU_BUS_ANSWER} ccu_bus_ph_t;
   // State of one unit
   typedef struct packed {
      logic      sync1;
      logic      sync2;
      logic      level;
      logic [3:0] presc;
      logic      out;
      logic      own;
      ccu_mode_t mode_seen;
      logic      match_q;
      ccu_word_t result;
   } ccu_unit_st_t;
endpackage : ccu_pkg

// ==== inc/ccu_unit_if.sv ====
`timescale 1ns/100ps
interface ccu_unit_if;
   import ccu_pkg::*;
   ccu_mode_t mode;    // Mode select of this unit
   ccu_word_t tcount;  // Count of the assigned timer
   logic      res_wr;  // Software write of result pair
   ccu_word_t wdata;   // Data of that write
   ccu_word_t result;  // Result pair
   logic      cap_hit; // Capture in this cycle
   logic      cmp_hit; // Compare match in this cycle
   logic      spec_hit;// Special event in this cycle
   logic      pin_out; // Compare output latch
   logic      pin_own; // Unit drives the pin
   modport ctl (output mode, tcount, res_wr, wdata,
                input result, cap_hit, cmp_hit, spec_hit,
                pin_out, pin_own);
   modport unit (input mode, tcount, res_wr, wdata,
                 output result, cap_hit, cmp_hit, spec_hit,
                 pin_out, pin_own);
endinterface : ccu_unit_if

// ==== tb/ccu_far_model.sv ====
`timescale 1ns/100ps
module ccu_far_model #(
   parameter int NUM_UNITS = 5
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Timer load from the bench
   input  wire logic                 load,
   input  wire logic [15:0]          a_set,
   input  wire logic [15:0]          b_set,
   // Timer reset from the block
   input  wire logic                 timer_a_reset,
   input  wire logic                 timer_b_reset,
   output logic      [15:0]          timer_a_count,
   output logic      [15:0]          timer_b_count,
   // Pins
   input  wire logic [NUM_UNITS-1:0] ext_level,
   input  wire logic [NUM_UNITS-1:0] pin_out,
   input  wire logic [NUM_UNITS-1:0] pin_own,
   output logic      [NUM_UNITS-1:0] pin_level
);
   // Timers held still in the system clock domain, loaded by the bench;
   // a stopped synchronous timer keeps expected captures exact
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_a_count <= 16'h0000;
         timer_b_count <= 16'h0000;
      end else begin
         // Reset pulse wins over a load in the same cycle
         if (timer_a_reset) begin
            timer_a_count <= 16'h0000;
         end else if (load) begin
            timer_a_count <= a_set;
         end
         if (timer_b_reset) begin
            timer_b_count <= 16'h0000;
         end else if (load) begin
            timer_b_count <= b_set;
         end
      end
   end
   // Pin is an output where the unit owns it, else the outside level
   assign pin_level = (pin_own & pin_out) | (~pin_own & ext_level);
endmodule : ccu_far_model

// ==== tb/ccu_top_asserts.sv ====
`timescale 1ns/100ps
`include "ccu_params.svh"
module ccu_top_asserts
   import ccu_pkg::*;
#(
   parameter int NUM_UNITS = 5
) (
   // Clock and reset
   input wire logic                 pclk,
   input wire logic                 presetn,
   // Bus
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [`CCU_AW-1:0]   paddr,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // Timers and converter
   input wire logic                 adc_enable,
   input wire logic                 timer_a_reset,
   input wire logic                 timer_b_reset,
   input wire logic                 adc_start,
   // Flags
   input wire logic [NUM_UNITS-1:0] unit_irq_flag,
   input wire logic [NUM_UNITS-1:0] unit_irq_req
);
   // ----
   // Helpers
   // ----
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic w1c; // Flag clear write commits at this edge
   assign w1c = psel && penable && pready && pwrite
                && (paddr == `CCU_OFS_FLAG);
   // ----
   // Properties
   // ----
   chk_ans_next: assert property (psel && penable && !pready |=> pready)
      else $error("access phase not answered");
   chk_ans_single: assert property (pready |=> !pready)
      else $error("answer stood too long");
   chk_err_with: assert property (pslverr |-> pready)
      else $error("error without answer");
   chk_flag_sticky: assert property (
      (|($past(unit_irq_flag) & ~unit_irq_flag)) |-> $past(w1c))
      else $error("flag fell without software clear");
   chk_req_after: assert property (
      (unit_irq_req & ~unit_irq_flag) == '0)
      else $error("request without flag");
   chk_treset_pulse: assert property (
      timer_a_reset || timer_b_reset |=> !timer_a_reset && !timer_b_reset)
      else $error("timer reset longer than one cycle");
   chk_adc_gated: assert property (adc_start |-> $past(adc_enable))
      else $error("conversion started while disabled");
   chk_adc_resets: assert property (
      adc_start |-> timer_a_reset || timer_b_reset)
      else $error("conversion start without timer reset");
   chk_reset_flagged: assert property (
      timer_a_reset || timer_b_reset
      |-> (|unit_irq_flag[1:0]) || $past(|unit_irq_flag[1:0]))
      else $error("timer reset without unit flag");
endmodule : ccu_top_asserts

bind ccu_top ccu_top_asserts #(.NUM_UNITS(NUM_UNITS)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .adc_enable(adc_enable), .timer_a_reset(timer_a_reset),
   .timer_b_reset(timer_b_reset), .adc_start(adc_start),
   .unit_irq_flag(unit_irq_flag), .unit_irq_req(unit_irq_req));

// ==== tb/ccu_top_tb.sv ====
`timescale 1ns/100ps
module ccu_top_tb;
   import ccu_pkg::*;
   localparam int N = 5;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, load = 1'b0, adc_enable = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, tar, tbr, adc_start;
   logic [15:0] ta, tbc, a_set = 16'h0, b_set = 16'h0;
   logic [N-1:0] pin_in, pin_out, pin_own, flag, req, ext = '0;
   int          errors = 0, cmp_count = 0, n_tres = 0, n_adc = 0, n_tbr = 0;
   logic [3:0]  modes [N] = '{4'h8, 4'hB, 4'h9, 4'h2, 4'hA};
   logic [N-1:0] post = 5'b01001;
   always #20 pclk = ~pclk;
   ccu_top #(.NUM_UNITS(N)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_a_count(ta), .timer_b_count(tbc), .adc_enable(adc_enable),
      .timer_a_reset(tar), .timer_b_reset(tbr), .adc_start(adc_start),
      .unit_pin_in(pin_in), .unit_pin_out(pin_out), .unit_pin_own(pin_own),
      .unit_irq_flag(flag), .unit_irq_req(req));
   ccu_far_model #(.NUM_UNITS(N)) u_far (.pclk(pclk), .presetn(presetn),
      .load(load), .a_set(a_set), .b_set(b_set), .timer_a_reset(tar),
      .timer_b_reset(tbr), .timer_a_count(ta), .timer_b_count(tbc),
      .ext_level(ext), .pin_out(pin_out), .pin_own(pin_own),
      .pin_level(pin_in));
   // Count one-cycle pulses towards the timers and the converter
   always @(posedge pclk) begin
      if (tar === 1'b1) n_tres++;
      if (tbr === 1'b1) n_tbr++;
      if (adc_start === 1'b1) n_adc++;
   end
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask : check
   // One bus transfer; holds the request until pready is sampled high
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) errors++;
   endtask : apb
   task automatic rdc(string nm, logic [11:0] a, logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(nm, rd, exp);
   endtask : rdc
   task automatic set_t(logic [15:0] a, logic [15:0] b);
      @(posedge pclk);
      a_set <= a; b_set <= b; load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask : set_t
   // Drive one outside pin level, then leave time for sync and capture
   task automatic pin_to(int k, logic v);
      @(posedge pclk);
      ext[k] <= v;
      repeat (6) @(posedge pclk);
   endtask : pin_to
   initial begin
      repeat (20000) @(posedge pclk);
      errors++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values and a refused address
      rdc("ctrl0", 12'h000, 32'h0);
      rdc("tsel", 12'h040, 32'h0);
      rdc("flags", 12'h044, 32'h0);
      apb(1'b0, 12'h080, 32'h0);
      check("bad addr err", 32'(err), 32'h1);
      check("bad addr data", rd, 32'h0);
      $display("test reset done");
      // Each timer setting, rising capture on all units; values change
      // every round so each read shows that round's capture
      for (int ts = 0; ts < 4; ts++) begin
         set_t(16'h1000 + 16'(ts), 16'h2000 + 16'(ts));
         apb(1'b1, 12'h040, (32'(ts / 2) << 6) | (32'(ts % 2) << 3));
         rdc("tsel", 12'h040, (32'(ts / 2) << 6) | (32'(ts % 2) << 3));
         for (int k = 0; k < N; k++) apb(1'b1, 12'(8 * k), 32'h5);
         @(posedge pclk) ext <= '1;
         repeat (6) @(posedge pclk);
         @(posedge pclk) ext <= '0;
         repeat (6) @(posedge pclk);
         for (int k = 0; k < N; k++)
            rdc("result", 12'(8 * k + 4), (ts == 0 || (ts == 1 && k == 0) ||
               (ts == 2 && k < 2)) ? 32'h1000 + ts : 32'h2000 + ts);
      end
      rdc("flags", 12'h044, 32'h1F);
      apb(1'b1, 12'h044, 32'h1F);
      rdc("flags", 12'h044, 32'h0);
      $display("test assign done");
      // Falling-edge capture ignores the rise
      apb(1'b1, 12'h000, 32'h4);
      pin_to(0, 1'b1);
      rdc("fall rise", 12'h044, 32'h0);
      pin_to(0, 1'b0);
      rdc("fall", 12'h044, 32'h1);
      // Prescaled captures from a cleared counter
      for (int m = 6; m < 8; m++) begin
         apb(1'b1, 12'h020, 32'h0);
         apb(1'b1, 12'h044, 32'h1F);
         apb(1'b1, 12'h020, 32'(m));
         repeat ((m == 6 ? 4 : 16) - 1) begin pin_to(4, 1'b1); pin_to(4, 1'b0); end
         rdc("presc early", 12'h044, 32'h0);
         pin_to(4, 1'b1);
         pin_to(4, 1'b0);
         rdc("presc", 12'h044, 32'h10);
      end
      // Prescale switch keeps the count: one rise, then 15 more capture
      apb(1'b1, 12'h020, 32'h6);
      pin_to(4, 1'b1);
      pin_to(4, 1'b0);
      apb(1'b1, 12'h020, 32'h7);
      apb(1'b1, 12'h044, 32'h1F);
      repeat (15) begin pin_to(4, 1'b1); pin_to(4, 1'b0); end
      rdc("presc kept", 12'h044, 32'h10);
      $display("test capture done");
      // Compare modes across all units on timer a
      adc_enable <= 1'b1;
      apb(1'b1, 12'h040, 32'h0);
      set_t(16'h0000, 16'hFFFF);
      for (int k = 0; k < N; k++) begin
         apb(1'b1, 12'(8 * k), 32'h0);
         apb(1'b1, 12'(8 * k + 4), 32'h40 + k);
      end
      for (int k = 0; k < N; k++) apb(1'b1, 12'(8 * k), 32'(modes[k]));
      // Enables only after the mode change and its flag clear
      apb(1'b1, 12'h044, 32'h1F);
      apb(1'b1, 12'h048, 32'h1F);
      repeat (4) @(posedge pclk);
      check("pin init", 32'(pin_out), 32'h04);
      check("pin own", 32'(pin_own), 32'h0D);
      for (int k = 0; k < N; k++) begin
         set_t(16'h40 + 16'(k), 16'hFFFF);
         if (k == 1) check("timer cleared", 32'(ta), 32'h0);
         check("pin match", 32'(pin_out[k]), 32'(post[k]));
         check("flag match", 32'(flag[k]), 32'h1);
      end
      check("timer resets", n_tres, 1);
      check("timer b resets", n_tbr, 0);
      check("adc starts", n_adc, 1);
      check("req", 32'(req), 32'h1F);
      set_t(16'h0000, 16'hFFFF);
      set_t(16'h0043, 16'hFFFF);
      check("toggle back", 32'(pin_out[3]), 32'h0);
      apb(1'b1, 12'h000, 32'h0);
      repeat (2) @(posedge pclk);
      check("ctrl clear", 32'(pin_out[0]), 32'h0);
      $display("test compare done");
      stop_test();
   end
endmodule : ccu_top_tb
